// *** inc/sadc_pkg.sv ***
// Constants, types and timing table of the converter sequencer
// Operation
// - Completion clashing with disable leaves result unchanged
// - Mode register write never clears done flag
// - Result and flag may reflect previous channel
// - Sampling lasts from about one tenth (code 0) up to one sixth of conversion
// - Ten-bit results from one of eight channels
// - Conversion starts only by software register write
// - Repeats conversions, interrupt after each one
// - Approximation register resolved MSB down to LSB
// - Approximation register copied to result at end
// - Result left-aligned, lower six bits zero
// - Result read as 16 bits, reset zero
// - Sampled input held during whole comparison
// - Mode bit 7 enables conversion, reset zero
// - Channel code bits 2..0 select input 0..7
// - Mode or channel write restarts conversion if bit 7 ends up set, else stops it
// - Time codes give 144,120,96,72,60,48 clocks
package sadc_pkg;

	// =====================================================
	// Register map
	localparam logic [15:0] MODE_ADDR   = 16'hff80;
	localparam logic [15:0] CHAN_ADDR   = 16'hff84;
	localparam logic [15:0] RESULT_ADDR = 16'hff14;

	// =====================================================
	// Field layout and reset values
	localparam int          MODE_EN_BIT   = 7;
	localparam int          MODE_TSEL_LSB = 3;
	localparam logic [7:0]  MODE_MASK     = 8'hb8;
	localparam logic [7:0]  MODE_RESET    = 8'h00;
	localparam logic [2:0]  CHAN_RESET    = 3'h0;
	localparam logic [15:0] RESULT_RESET  = 16'h0000;
	localparam int          RES_BITS      = 10;
	localparam int          RES_PAD       = 6;
	localparam logic [9:0]  SAR_MSB_TRIAL = 10'h200;

	// =====================================================
	// Conversion times in system clocks
	localparam logic [7:0] CONV_CYC_000 = 8'd144;
	localparam logic [7:0] CONV_CYC_001 = 8'd120;
	localparam logic [7:0] CONV_CYC_010 = 8'd96;
	localparam logic [7:0] CONV_CYC_100 = 8'd72;
	localparam logic [7:0] CONV_CYC_101 = 8'd60;
	localparam logic [7:0] CONV_CYC_110 = 8'd48;
	localparam logic [7:0] SAMPLE_DIV   = 8'd10;

	typedef enum logic [1:0] {
		SADC_IDLE    = 2'b00,
		SADC_SAMPLE  = 2'b01,
		SADC_CONVERT = 2'b10
	} sadc_state_t;

	// Total clocks for a time code; prohibited codes fall back to 144
	function automatic logic [7:0] sadc_conv_cyc(input logic [2:0] sel);
		case (sel)
			3'h1: sadc_conv_cyc = CONV_CYC_001;
			3'h2: sadc_conv_cyc = CONV_CYC_010;
			3'h4: sadc_conv_cyc = CONV_CYC_100;
			3'h5: sadc_conv_cyc = CONV_CYC_101;
			3'h6: sadc_conv_cyc = CONV_CYC_110;
			default: sadc_conv_cyc = CONV_CYC_000;
		endcase
	endfunction

	// One comparison step: what is left after a tenth, split ten ways
	function automatic logic [7:0] sadc_step_cyc(input logic [2:0] sel);
		logic [7:0] c;
		c = sadc_conv_cyc(sel);
		sadc_step_cyc = (c - c / SAMPLE_DIV) / SAMPLE_DIV;
	endfunction

	// Sampling takes the remainder, so steps plus sample sum exactly
	function automatic logic [7:0] sadc_samp_cyc(input logic [2:0] sel);
		logic [7:0] s;
		s = sadc_step_cyc(sel);
		sadc_samp_cyc = 8'(sadc_conv_cyc(sel) - 8'(s * 8'd10));
	endfunction

endpackage

// *** inc/sadc_tmr_if.sv ***
// Phase timer carrier between sequencer and its timer
`timescale 1ns/1ps
interface sadc_tmr_if;
	logic       load;     // Start a new phase
	logic [7:0] load_val; // Phase length in clocks
	logic       expire;   // Last clock of the phase

	modport ctl (output load, output load_val, input expire);
	modport tmr (input load, input load_val, output expire);
endinterface

// *** hw/sadc_phase_timer.sv ***
// Down-counting phase timer for sampling and comparison steps
`timescale 1ns/1ps
module sadc_phase_timer (
	input  wire logic i_mclk,    // System clock
	input  wire logic i_sys_rst, // Synchronous reset, high
	sadc_tmr_if.tmr   tmr        // Phase requests
);
	typedef struct packed {
		logic [7:0] cnt;
	} sadc_tmr_st_t;

	sadc_tmr_st_t tmr_reg;
	sadc_tmr_st_t tmr_next;

	// =====================================================
	// Count down; a load of N expires N clocks later
	always_comb begin
		tmr_next = tmr_reg;
		if (tmr.load) begin
			tmr_next.cnt = tmr.load_val;
		end else if (tmr_reg.cnt != 8'h00) begin
			tmr_next.cnt = tmr_reg.cnt - 8'h01;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			tmr_reg <= '0;
		end else begin
			tmr_reg <= tmr_next;
		end
	end

	// Reload in the expiring cycle wins, so phases abut cleanly
	assign tmr.expire = (tmr_reg.cnt == 8'h01);
endmodule

// *** hw/sadc_sequencer.sv ***
// Successive-approximation converter sequencer with its registers
`timescale 1ns/1ps
module sadc_sequencer (
	input  wire logic        i_mclk,          // System clock 125 MHz
	input  wire logic        i_sys_rst,       // Synchronous reset, high
	input  wire logic        i_wr_en,         // Register write strobe
	input  wire logic        i_rd_en,         // Register read strobe
	input  wire logic [15:0] i_addr,          // Register address
	input  wire logic [7:0]  i_wdata,         // Write data
	input  wire logic        i_done_flag_clr, // Clear done flag
	input  wire logic        i_cmp_high,      // Comparator, async
	output logic      [15:0] o_rdata,         // Read data, next clock
	output logic             o_conversion_done_flag, // Sticky done
	output logic             o_conversion_done_irq,  // Done pulse
	output logic             o_sample,        // Sample-hold tracking
	output logic      [9:0]  o_tap_code,      // Tap selector code
	output logic      [2:0]  o_channel_sel    // Selected input
);
	typedef struct packed {
		sadc_pkg::sadc_state_t state;
		logic [7:0]            mode;
		logic [2:0]            chan;
		logic [9:0]            sar;
		logic [3:0]            bit_idx;
		logic [15:0]           result;
		logic                  flag;
		logic                  irq;
		logic                  sample;
		logic [15:0]           rdata;
		logic [2:0]            cmp_sync;
		logic                  cmp;
		logic [7:0]            samp_cnt;
	} sadc_st_t;

	sadc_st_t   st_reg;
	sadc_st_t   st_next;
	sadc_tmr_if tmr_bus ();

	logic       mode_wr;
	logic       chan_wr;
	logic       new_en;
	logic [2:0] tsel;
	logic [2:0] new_tsel;
	logic [9:0] sar_dec;
	logic [9:0] bit_mask;
	logic       last_step;
	logic       cmp_now;

	sadc_phase_timer u_timer (
		.i_mclk    (i_mclk),
		.i_sys_rst (i_sys_rst),
		.tmr       (tmr_bus.tmr)
	);

	// =====================================================
	// Decode of writes and the current comparison step
	assign mode_wr  = i_wr_en && (i_addr == sadc_pkg::MODE_ADDR);
	assign chan_wr  = i_wr_en && (i_addr == sadc_pkg::CHAN_ADDR);
	assign tsel     = st_reg.mode[sadc_pkg::MODE_TSEL_LSB +: 3];
	assign new_tsel = mode_wr ? i_wdata[sadc_pkg::MODE_TSEL_LSB +: 3]
	                          : tsel;
	assign new_en   = mode_wr ? i_wdata[sadc_pkg::MODE_EN_BIT]
	                          : st_reg.mode[sadc_pkg::MODE_EN_BIT];
	assign bit_mask = 10'h001 << st_reg.bit_idx;
	// Use the filtered answer as soon as the two late stages agree; the
	// registered copy would cost a clock and starve the 4-clock step
	assign cmp_now  = (st_reg.cmp_sync[2] == st_reg.cmp_sync[1])
	                  ? st_reg.cmp_sync[2] : st_reg.cmp;
	// Keep the trial bit only if the input is at or above the tap
	assign sar_dec  = cmp_now ? st_reg.sar
	                          : (st_reg.sar & ~bit_mask);
	assign last_step = (st_reg.state == sadc_pkg::SADC_CONVERT)
	                   && tmr_bus.expire && (st_reg.bit_idx == 4'h0);

	// =====================================================
	// Next-state logic
	always_comb begin
		st_next          = st_reg;
		st_next.irq      = 1'b0;
		tmr_bus.load     = 1'b0;
		tmr_bus.load_val = 8'h00;
		// Three stages; a change counts once the last two agree
		st_next.cmp_sync = {st_reg.cmp_sync[1:0], i_cmp_high};
		if (st_reg.cmp_sync[2] == st_reg.cmp_sync[1]) begin
			st_next.cmp = st_reg.cmp_sync[2];
		end
		if (st_reg.state == sadc_pkg::SADC_SAMPLE) begin
			st_next.samp_cnt = st_reg.samp_cnt + 8'h01;
		end else begin
			st_next.samp_cnt = 8'h00;
		end
		if (mode_wr) begin
			st_next.mode = i_wdata & sadc_pkg::MODE_MASK;
		end
		if (chan_wr) begin
			st_next.chan = i_wdata[2:0];
		end
		// Register write cancels any conversion and wins over its end,
		// so the clashing result is dropped and no interrupt fires.
		// The done flag is left alone here.
		if (mode_wr || chan_wr) begin
			st_next.sar      = '0;
			st_next.bit_idx  = 4'h0;
			st_next.samp_cnt = 8'h00;
			if (new_en) begin
				st_next.state    = sadc_pkg::SADC_SAMPLE;
				st_next.sample   = 1'b1;
				tmr_bus.load     = 1'b1;
				tmr_bus.load_val = sadc_pkg::sadc_samp_cyc(new_tsel);
			end else begin
				st_next.state  = sadc_pkg::SADC_IDLE;
				st_next.sample = 1'b0;
			end
		end else begin
			case (st_reg.state)
				sadc_pkg::SADC_SAMPLE: begin
					// Hold from here until the last bit is decided
					if (tmr_bus.expire) begin
						st_next.state    = sadc_pkg::SADC_CONVERT;
						st_next.sample   = 1'b0;
						st_next.sar      = sadc_pkg::SAR_MSB_TRIAL;
						st_next.bit_idx  = 4'(sadc_pkg::RES_BITS - 1);
						tmr_bus.load     = 1'b1;
						tmr_bus.load_val = sadc_pkg::sadc_step_cyc(tsel);
					end
				end
				sadc_pkg::SADC_CONVERT: begin
					if (last_step) begin
						st_next.result = {sar_dec,
						                  {sadc_pkg::RES_PAD{1'b0}}};
						st_next.flag     = 1'b1;
						st_next.irq      = 1'b1;
						st_next.state    = sadc_pkg::SADC_SAMPLE;
						st_next.sample   = 1'b1;
						st_next.sar      = '0;
						tmr_bus.load     = 1'b1;
						tmr_bus.load_val = sadc_pkg::sadc_samp_cyc(tsel);
					end else if (tmr_bus.expire) begin
						st_next.sar      = sar_dec | (bit_mask >> 1);
						st_next.bit_idx  = st_reg.bit_idx - 4'h1;
						tmr_bus.load     = 1'b1;
						tmr_bus.load_val = sadc_pkg::sadc_step_cyc(tsel);
					end
				end
				default: begin
					st_next.state  = sadc_pkg::SADC_IDLE;
					st_next.sample = 1'b0;
				end
			endcase
		end
		// A new completion wins over a clear in the same clock
		if (i_done_flag_clr && !st_next.irq) begin
			st_next.flag = 1'b0;
		end
		// Read data is taken before this clock's result load
		if (i_rd_en) begin
			case (i_addr)
				sadc_pkg::MODE_ADDR:   st_next.rdata = {8'h00, st_reg.mode};
				sadc_pkg::CHAN_ADDR:   st_next.rdata = {13'h0000, st_reg.chan};
				sadc_pkg::RESULT_ADDR: st_next.rdata = st_reg.result;
				default:               st_next.rdata = 16'h0000;
			endcase
		end
	end

	// =====================================================
	// State register
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			st_reg        <= '0;
			st_reg.state  <= sadc_pkg::SADC_IDLE;
			st_reg.mode   <= sadc_pkg::MODE_RESET;
			st_reg.chan   <= sadc_pkg::CHAN_RESET;
			st_reg.result <= sadc_pkg::RESULT_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs come straight from the state register
	assign o_rdata                = st_reg.rdata;
	assign o_conversion_done_flag = st_reg.flag;
	assign o_conversion_done_irq  = st_reg.irq;
	assign o_sample               = st_reg.sample;
	assign o_tap_code             = st_reg.sar;
	assign o_channel_sel          = st_reg.chan;

	// =====================================================
	// Checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);

	sequence sample_end_s;
		(st_reg.state == sadc_pkg::SADC_SAMPLE) && tmr_bus.expire
		&& !mode_wr && !chan_wr;
	endsequence

	sequence msb_trial_s;
		(st_reg.state == sadc_pkg::SADC_CONVERT)
		&& (st_reg.sar == sadc_pkg::SAR_MSB_TRIAL) && !o_sample;
	endsequence

	result_low_zero_a: assert property (
		st_reg.result[5:0] == 6'h00)
		else $error("result low bits not zero");
	mode_keeps_flag_a: assert property (
		mode_wr && !i_done_flag_clr |=> o_conversion_done_flag
		== $past(o_conversion_done_flag))
		else $error("mode write changed done flag");
	write_restarts_a: assert property (
		(mode_wr || chan_wr) && new_en |=> o_sample && !o_conversion_done_irq
		&& (st_reg.state == sadc_pkg::SADC_SAMPLE))
		else $error("write did not restart conversion");
	clash_drops_a: assert property (
		last_step && mode_wr |=> !o_conversion_done_irq
		&& $stable(st_reg.result))
		else $error("clashing completion loaded result");
	idle_stays_a: assert property (
		(st_reg.state == sadc_pkg::SADC_IDLE) && !i_wr_en
		|=> st_reg.state == sadc_pkg::SADC_IDLE)
		else $error("conversion started without a write");
	sample_length_a: assert property (
		sample_end_s |-> st_reg.samp_cnt + 8'h01
		== sadc_pkg::sadc_samp_cyc(tsel))
		else $error("sampling phase length wrong");
	msb_first_a: assert property (
		sample_end_s |=> msb_trial_s ##0 (st_reg.bit_idx == 4'd9))
		else $error("conversion did not start at msb");
	result_load_a: assert property (
		last_step && !mode_wr && !chan_wr |=> o_conversion_done_irq
		&& o_conversion_done_flag && (st_reg.result[15:6] == $past(sar_dec)))
		else $error("result not loaded at end");
	hold_steady_a: assert property (
		(st_reg.state == sadc_pkg::SADC_CONVERT) |-> !o_sample)
		else $error("sampling during comparison");
	repeat_conv_a: assert property (
		o_conversion_done_irq |-> o_sample
		##1 !o_conversion_done_irq)
		else $error("no restart after completion");
endmodule

// *** verif/sadc_analog_model.sv ***
// Behavioural comparator, sample-hold and input mux facing the sequencer
`timescale 1ns/1ps
module sadc_analog_model (
	input  wire logic       i_mclk,      // System clock
	input  wire logic       i_sample,    // Tracking when high
	input  wire logic [9:0] i_tap,       // Tap selector code
	input  wire logic [2:0] i_chan,      // Selected input
	input  wire logic [9:0] i_level [8], // Input levels in taps
	input  wire logic       i_slow,      // One clock late answer
	output logic            o_cmp        // Input at or above tap
);
	logic [9:0] held_reg   = 10'h155;
	logic       cmp_reg    = 1'b0;
	logic       wobble_reg = 1'b0;

	// Hold freezes the sampled level for the whole comparison; the
	// shared pins are only ever seen here as levels, never read as a
	// digital port while selected
	always @(posedge i_mclk) begin
		if (i_sample)
			held_reg <= i_level[i_chan];
		cmp_reg <= (held_reg >= i_tap);
		wobble_reg <= ~wobble_reg;
	end

	// While tracking the answer is meaningless, so it keeps toggling
	assign o_cmp = i_sample ? wobble_reg :
		(i_slow ? cmp_reg : (held_reg >= i_tap));
endmodule

// *** verif/test_sar_adc_sequencer.sv ***
// Self-checking bench of the converter sequencer
`timescale 1ns/1ps
module test_sar_adc_sequencer;
	// =====================================================
	// Stimulus and observed signals
	logic        i_mclk          = 1'b0;
	logic        i_sys_rst       = 1'b1;
	logic        i_wr_en         = 1'b0;
	logic        i_rd_en         = 1'b0;
	logic [15:0] i_addr          = 16'h0000;
	logic [7:0]  i_wdata         = 8'h00;
	logic        i_done_flag_clr = 1'b0;
	logic        slow            = 1'b0;
	logic        cmp_high;
	logic [15:0] rdata;
	logic        flag;
	logic        irq;
	logic        sample;
	logic [9:0]  tap;
	logic [2:0]  chan;
	logic [9:0]  level [8]       = '{10'h0c3, 10'h011, 10'h2a5, 10'h15a,
		10'h3ff, 10'h000, 10'h201, 10'h1ff};
	int          codes [6]       = '{0, 1, 2, 4, 5, 6};
	int          cycs [6]        = '{144, 120, 96, 72, 60, 48};
	int          err_count       = 0;
	int          checks_done     = 0;

	// 125 MHz system clock
	always #4 i_mclk = ~i_mclk;

	sadc_sequencer uut (
		.i_mclk                 (i_mclk),
		.i_sys_rst              (i_sys_rst),
		.i_wr_en                (i_wr_en),
		.i_rd_en                (i_rd_en),
		.i_addr                 (i_addr),
		.i_wdata                (i_wdata),
		.i_done_flag_clr        (i_done_flag_clr),
		.i_cmp_high             (cmp_high),
		.o_rdata                (rdata),
		.o_conversion_done_flag (flag),
		.o_conversion_done_irq  (irq),
		.o_sample               (sample),
		.o_tap_code             (tap),
		.o_channel_sel          (chan)
	);

	sadc_analog_model analog (
		.i_mclk   (i_mclk),
		.i_sample (sample),
		.i_tap    (tap),
		.i_chan   (chan),
		.i_level  (level),
		.i_slow   (slow),
		.o_cmp    (cmp_high)
	);

	// =====================================================
	// Shared tasks
	task automatic complete_run();
		$display("compares %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge i_mclk);
		i_wr_en = 1'b1;
		i_addr = a;
		i_wdata = d;
		@(negedge i_mclk);
		i_wr_en = 1'b0;
	endtask

	// Read data stands until the next read, so take it a clock later
	task automatic rd(input logic [15:0] a, output logic [15:0] q);
		@(negedge i_mclk);
		i_rd_en = 1'b1;
		i_addr = a;
		@(negedge i_mclk);
		i_rd_en = 1'b0;
		@(negedge i_mclk);
		q = rdata;
	endtask

	task automatic pulse_clr();
		@(negedge i_mclk);
		i_done_flag_clr = 1'b1;
		@(negedge i_mclk);
		i_done_flag_clr = 1'b0;
	endtask

	// Clocks to the next irq pulse, and how many of them were sampling
	task automatic wait_irq(output int n, output int s);
		n = 0;
		s = 0;
		do begin
			s += int'(sample === 1'b1);
			@(posedge i_mclk);
			#1;
			n++;
		end while (irq !== 1'b1 && n < 400);
		if (n >= 400) begin
			err_count++;
			complete_run();
		end
	endtask

	task automatic quiet(input int len, output int k);
		k = 0;
		repeat (len) begin
			@(negedge i_mclk);
			k += int'(irq !== 1'b0 || sample !== 1'b0
			          || tap !== 10'h000);
		end
	endtask

	// =====================================================
	// Scenarios
	task automatic test_reset();
		logic [15:0] q;
		int          k;
		rd(sadc_pkg::RESULT_ADDR, q);
		check(q, 16'h0000);
		rd(sadc_pkg::MODE_ADDR, q);
		check(q, 16'h0000);
		rd(sadc_pkg::CHAN_ADDR, q);
		check(q, 16'h0000);
		quiet(200, k);
		check(16'(k) | {15'h0, flag}, 16'h0000);
		$display("reset test done");
	endtask

	// Each of the six valid time codes, a channel each, first and repeated conversion
	task automatic test_codes();
		logic [15:0] q;
		int          n;
		int          s;
		int          t;
		int          st;
		for (int i = 0; i < 6; i++) begin
			t = cycs[i];
			st = (t - t / 10) / 10;
			slow = (i == 0);
			pulse_clr();
			wr(sadc_pkg::CHAN_ADDR, 8'(i + 2));
			wr(sadc_pkg::MODE_ADDR, 8'h80 | 8'(codes[i] << 3));
			wait_irq(n, s);
			check(16'(n), 16'(t));
			check({15'h0, flag}, 16'h0001);
			check({13'h0, chan}, 16'(i + 2));
			wait_irq(n, s);
			check(16'(n), 16'(t));
			check(16'(s), 16'(t - 10 * st));
			rd(sadc_pkg::RESULT_ADDR, q);
			check(q, {level[i + 2], 6'h00});
		end
		$display("time code test done");
	endtask

	task automatic test_rewrite();
		logic [15:0] q;
		int          n;
		int          s;
		wr(sadc_pkg::CHAN_ADDR, 8'h00);
		check({15'h0, flag}, 16'h0001);
		rd(sadc_pkg::RESULT_ADDR, q);
		check(q, {level[7], 6'h00});
		wr(sadc_pkg::MODE_ADDR, 8'hb0);
		check({15'h0, flag}, 16'h0001);
		wait_irq(n, s);
		check(16'(n), 16'd48);
		rd(sadc_pkg::RESULT_ADDR, q);
		check(q, {level[0], 6'h00});
		pulse_clr();
		check({15'h0, flag}, 16'h0000);
		$display("rewrite test done");
	endtask

	// Stop well before the next completion so the result stays valid
	task automatic test_stop();
		logic [15:0] q;
		int          k;
		wr(sadc_pkg::MODE_ADDR, 8'h30);
		quiet(200, k);
		check(16'(k), 16'h0000);
		rd(sadc_pkg::RESULT_ADDR, q);
		check(q, {level[0], 6'h00});
		$display("stop test done");
	endtask

	// Stop lands in the very clock of a completion: no irq, no load
	task automatic test_clash();
		logic [15:0] q;
		int          k;
		wr(sadc_pkg::CHAN_ADDR, 8'h03);
		wr(sadc_pkg::MODE_ADDR, 8'hb0);
		repeat (46) @(negedge i_mclk);
		wr(sadc_pkg::MODE_ADDR, 8'h30);
		quiet(200, k);
		check(16'(k) | {15'h0, flag}, 16'h0000);
		rd(sadc_pkg::RESULT_ADDR, q);
		check(q, {level[0], 6'h00});
		$display("clash test done");
	endtask

	task automatic test_fields();
		logic [15:0] q;
		wr(sadc_pkg::MODE_ADDR, 8'hff);
		rd(sadc_pkg::MODE_ADDR, q);
		check(q, 16'h00b8);
		wr(sadc_pkg::MODE_ADDR, 8'h00);
		wr(sadc_pkg::CHAN_ADDR, 8'hff);
		rd(sadc_pkg::CHAN_ADDR, q);
		check(q, 16'h0007);
		check({13'h0, chan}, 16'h0007);
		wr(sadc_pkg::RESULT_ADDR, 8'h55);
		rd(sadc_pkg::RESULT_ADDR, q);
		check(q, {level[0], 6'h00});
		rd(16'h1234, q);
		check(q, 16'h0000);
		$display("field test done");
	endtask

	// Main sequence
	initial begin
		repeat (20) @(negedge i_mclk);
		i_sys_rst = 1'b0;
		test_reset();
		test_codes();
		test_rewrite();
		test_stop();
		test_clash();
		test_fields();
		complete_run();
	end
endmodule
